// file: src/ddr_pkg.sv
package ddr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NCH    = 2;

  localparam logic [7:0] OFS_SECOND_CTRL = 8'h01;
  localparam logic [7:0] OFS_INTEN_CLR   = 8'h04;
  localparam logic [7:0] OFS_INTEN_SET   = 8'h05;
  localparam logic [7:0] OFS_INTFLAG     = 8'h06;
  localparam logic [7:0] OFS_STATUS      = 8'h07;
  localparam logic [7:0] OFS_CH0_CTRL    = 8'h0c;
  localparam logic [7:0] OFS_CH1_CTRL    = 8'h0e;
  localparam logic [7:0] OFS_CH0_DATA    = 8'h1c;
  localparam logic [7:0] OFS_CH1_DATA    = 8'h1e;

  localparam int DIFFERENTIAL_ENABLE_BIT     = 0;
  localparam int CTL_EN_BIT   = 0;
  localparam int CTL_RSTBY    = 6;
  localparam int CTL_RF_LSB   = 8;
  localparam logic [15:0] CTL_MASK = 16'h0f41;
  localparam int EMPTY_LSB    = 2;
  localparam int UNDERRUN_LSB = 0;
  localparam int EOC_LSB      = 2;
  localparam int READY_LSB    = 0;
  localparam logic [11:0] SIGN_FLIP = 12'h800;
  localparam logic [3:0]  RF_MIN    = 4'h2;

  localparam int CLK_MHZ    = 50;
  localparam int STARTUP_NS = 12000;
  localparam int CONV_NS    = 1000;
  localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_CYC    = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int TCNT_W      = 10;

  typedef enum logic [1:0] {CH_OFF, CH_START, CH_IDLE, CH_CONV} ddr_ch_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ddr_bus_req_t;

  typedef struct packed {
    logic [11:0] positive_analog_out;
    logic [11:0] negative_analog_out;
  } ddr_aout_t;

  typedef struct packed {
    logic                              differential_enable;
    logic [NCH-1:0][15:0]              ctrl;
    logic [NCH-1:0][11:0]              data;
    logic [3:0]                        inten;
    logic [3:0]                        intflag;
    logic [NCH-1:0]                    eoc;
    logic [NCH-1:0]                    pend;
    logic [NCH-1:0]                    rdue;
    logic [NCH-1:0][3:0]               rcnt;
    logic [NCH-1:0][TCNT_W-1:0]        tcnt;
    ddr_ch_state_t [NCH-1:0]           st;
    logic [NCH-1:0][11:0]              cv;
    logic [NCH-1:0][11:0]              out;
    logic [DATA_W-1:0]                 rdata;
  } ddr_state_t;

  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
  } ddr_sync_state_t;
endpackage : ddr_pkg

// file: src/ddr_lp_tick.sv
`timescale 1ns/1ns
`default_nettype none
module ddr_lp_tick (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_lp_clk,
  output logic      o_tick
);
  ddr_pkg::ddr_sync_state_t s;
  ddr_pkg::ddr_sync_state_t next_s;

  // a level only counts once stages two and three agree
  always_comb
  begin
    next_s    = s;
    next_s.sh = {s.sh[1:0], i_lp_clk};
    o_tick    = 1'b0;
    if (s.sh[1] == s.sh[2])
    begin
      next_s.lvl = s.sh[2];
      o_tick     = s.sh[2] & ~s.lvl;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      s <= '0;
    else
      s <= next_s;
  end
endmodule : ddr_lp_tick
`default_nettype wire

// file: src/ddr_refresh_ctrl.sv
// Overview of operation
// - refresh conversion starts every refresh-setting periods of the 32 kHz clock.
// - refresh setting zero disables refresh; setting one is reserved, treated as off.
// - when the refresh period lapses without new data, the held value converts again.
// - in standby refresh continues only for channels with run_in_standby set.
// - data written during a conversion waits until the channel can start again.
// - differential mode converts channel0 data on both channels together, 0 positive.
// - differential data is two's complement with bit 11 as sign.
// - in differential mode channel0 control configures both; channel1 control ignored.
// - differential_enable in second_control_reg turns differential mode on and off.
// - writing one to bits 3 and 2 disables the buffer empty interrupts.
// - writing one to bits 1 and 0 disables the underrun interrupts.
// - conversion done bits set on completion, cleared by a data write.
// - startup ready bits read zero until the startup time elapses.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ddr_refresh_ctrl #(
  parameter int STARTUP_CYC = ddr_pkg::STARTUP_CYC,
  parameter int CONV_CYC    = ddr_pkg::CONV_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire ddr_pkg::ddr_bus_req_t i_bus,
  output logic [ddr_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                  i_lp_clk,
  input  wire logic                  i_standby,
  output ddr_pkg::ddr_aout_t         o_aout,
  output logic [1:0]                 o_conv_done,
  output logic                       o_int_req
);
  ddr_pkg::ddr_state_t s;
  ddr_pkg::ddr_state_t n;
  logic                lp_tick;
  logic [1:0]          wr_data;
  logic [1:0]          pend_wr;
  logic [1:0]          active;
  logic [1:0]          go_new;
  logic [1:0]          go_rf;
  logic [1:0]          done;
  logic [1:0][15:0]    cfg;
  logic [1:0][3:0]     rf_set;
  logic [1:0]          ready;
  logic [1:0]          rf_on;
  // local copy keeps the counter compare casts short
  localparam int       TCNT_W = ddr_pkg::TCNT_W;

  ddr_lp_tick ddr_lp_tick_inst (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_lp_clk  (i_lp_clk),
    .o_tick    (lp_tick)
  );

  always_comb
  begin
    n       = s;
    n.rdata = '0;
    wr_data = '0;
    pend_wr = '0;
    active  = '0;
    go_new  = '0;
    go_rf   = '0;
    done    = '0;
    cfg     = '0;
    rf_set  = '0;
    ready   = '0;
    rf_on   = '0;
    if (i_bus.wr)
    begin
      case (i_bus.addr)
        ddr_pkg::OFS_SECOND_CTRL: n.differential_enable = i_bus.wdata[ddr_pkg::DIFFERENTIAL_ENABLE_BIT];
        ddr_pkg::OFS_INTEN_CLR:   n.inten = s.inten & ~i_bus.wdata[3:0];
        ddr_pkg::OFS_INTEN_SET:   n.inten = s.inten | i_bus.wdata[3:0];
        ddr_pkg::OFS_INTFLAG:     n.intflag = s.intflag & ~i_bus.wdata[3:0];
        ddr_pkg::OFS_CH0_CTRL:    n.ctrl[0] = i_bus.wdata & ddr_pkg::CTL_MASK;
        ddr_pkg::OFS_CH1_CTRL:    n.ctrl[1] = i_bus.wdata & ddr_pkg::CTL_MASK;
        ddr_pkg::OFS_CH0_DATA:    wr_data[0] = 1'b1;
        ddr_pkg::OFS_CH1_DATA:    wr_data[1] = 1'b1;
        default:                  n.rdata = '0;
      endcase
    end
    for (int i = 0; i < 2; i++)
    begin
      // channel1 follows channel0 configuration in differential mode
      cfg[i]    = s.differential_enable ? s.ctrl[0] : s.ctrl[i];
      rf_set[i] = cfg[i][ddr_pkg::CTL_RF_LSB +: 4];
      pend_wr[i] = s.differential_enable ? wr_data[0] : wr_data[i];
      active[i] = cfg[i][ddr_pkg::CTL_EN_BIT] & (~i_standby | cfg[i][ddr_pkg::CTL_RSTBY]);
      ready[i]  = (s.st[i] == ddr_pkg::CH_IDLE) || (s.st[i] == ddr_pkg::CH_CONV);
      // a refresh left due from before refresh was turned off must not fire afterwards
      rf_on[i]  = active[i] && (rf_set[i] >= ddr_pkg::RF_MIN);
      if (wr_data[i])
        n.data[i] = i_bus.wdata[11:0];
      if (!rf_on[i])
      begin
        n.rcnt[i] = '0;
        n.rdue[i] = 1'b0;
      end
      else if (lp_tick && !s.rdue[i])
      begin
        if (s.rcnt[i] + 4'h1 >= rf_set[i])
        begin
          n.rcnt[i] = '0;
          n.rdue[i] = 1'b1;
        end
        else
          n.rcnt[i] = s.rcnt[i] + 4'h1;
      end
      unique case (s.st[i])
        ddr_pkg::CH_OFF:
        begin
          n.tcnt[i] = '0;
          if (cfg[i][ddr_pkg::CTL_EN_BIT])
            n.st[i] = ddr_pkg::CH_START;
        end
        ddr_pkg::CH_START:
        begin
          n.tcnt[i] = s.tcnt[i] + 1'b1;
          if (s.tcnt[i] == TCNT_W'(STARTUP_CYC - 1))
          begin
            n.st[i]   = ddr_pkg::CH_IDLE;
            n.tcnt[i] = '0;
          end
        end
        ddr_pkg::CH_IDLE:
        begin
          go_new[i] = s.pend[i];
          go_rf[i]  = ~s.pend[i] & s.rdue[i] & rf_on[i];
        end
        ddr_pkg::CH_CONV:
        begin
          n.tcnt[i] = s.tcnt[i] + 1'b1;
          if (s.tcnt[i] == TCNT_W'(CONV_CYC - 1))
          begin
            done[i]   = 1'b1;
            n.st[i]   = ddr_pkg::CH_IDLE;
            n.tcnt[i] = '0;
          end
        end
      endcase
      if (go_new[i] || go_rf[i])
      begin
        n.st[i]   = ddr_pkg::CH_CONV;
        n.tcnt[i] = '0;
        n.rcnt[i] = '0;
        n.rdue[i] = 1'b0;
        n.pend[i] = 1'b0;
        if (!s.differential_enable)
          n.cv[i] = s.data[i];
        else if (i == 0)
          n.cv[i] = s.data[0] ^ ddr_pkg::SIGN_FLIP;
        else
          n.cv[i] = ~(s.data[0] ^ ddr_pkg::SIGN_FLIP);
      end
      // flags are set after the software clear above, so an event in the clearing cycle wins
      if (go_new[i])
        n.intflag[ddr_pkg::EMPTY_LSB + i] = 1'b1;
      if (go_rf[i])
        n.intflag[ddr_pkg::UNDERRUN_LSB + i] = 1'b1;
      // a write during a conversion marks the value pending and clears the done bit
      if (pend_wr[i])
      begin
        n.pend[i] = 1'b1;
        n.eoc[i]  = 1'b0;
      end
      // the done bit is set after the write clear, so completion wins a tie
      if (done[i])
      begin
        n.out[i] = s.cv[i];
        n.eoc[i] = 1'b1;
      end
      if (!cfg[i][ddr_pkg::CTL_EN_BIT])
      begin
        n.st[i]   = ddr_pkg::CH_OFF;
        n.tcnt[i] = '0;
      end
    end
    // lockstep keeps both outputs changing in the same cycle
    if (n.differential_enable)
    begin
      n.st[1]   = n.st[0];
      n.tcnt[1] = n.tcnt[0];
      n.rcnt[1] = n.rcnt[0];
      n.rdue[1] = n.rdue[0];
      n.pend[1] = n.pend[0];
    end
    // read data stand for one cycle; every other cycle returns zero
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        ddr_pkg::OFS_SECOND_CTRL: n.rdata = 16'(s.differential_enable);
        ddr_pkg::OFS_INTEN_CLR:   n.rdata = {12'h000, s.inten};
        ddr_pkg::OFS_INTEN_SET:   n.rdata = {12'h000, s.inten};
        ddr_pkg::OFS_INTFLAG:     n.rdata = {12'h000, s.intflag};
        ddr_pkg::OFS_STATUS:      n.rdata = {12'h000, s.eoc, ready};
        ddr_pkg::OFS_CH0_CTRL:    n.rdata = s.ctrl[0];
        ddr_pkg::OFS_CH1_CTRL:    n.rdata = s.ctrl[1];
        ddr_pkg::OFS_CH0_DATA:    n.rdata = {4'h0, s.data[0]};
        ddr_pkg::OFS_CH1_DATA:    n.rdata = {4'h0, s.data[1]};
        default:                  n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      s <= '0;
    else
      s <= n;
  end

  assign o_rdata     = s.rdata;
  assign o_aout      = {s.out[0], s.out[1]};
  assign o_conv_done = s.eoc;
  assign o_int_req   = |(s.intflag & s.inten);

  chk_refresh_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (rf_set[0] < ddr_pkg::RF_MIN) |-> !go_rf[0])
    else $error("refresh started while refresh is off");

  chk_refresh_count: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (lp_tick && active[0] && rf_set[0] >= ddr_pkg::RF_MIN && !s.rdue[0] && s.rcnt[0] == rf_set[0] - 4'h1
     && !go_new[0]) |=> s.rdue[0])
    else $error("refresh period not detected");

  chk_standby_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_standby && !cfg[1][ddr_pkg::CTL_RSTBY]) |-> ##1 !s.rdue[1])
    else $error("refresh due in standby without run_in_standby");

  chk_defer_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pend_wr[0] && s.st[0] == ddr_pkg::CH_CONV && !done[0]) |=> s.pend[0] && s.st[0] == ddr_pkg::CH_CONV)
    else $error("write during conversion not deferred");

  chk_differential_enable_lockstep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.differential_enable |-> s.st[0] == s.st[1])
    else $error("channels not in lockstep in differential mode");

  chk_differential_enable_output: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s.differential_enable && go_new[0]) |-> ##(CONV_CYC + 1) (s.out[0] == ~s.out[1]))
    else $error("differential outputs not balanced");

  chk_differential_enable_enable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_bus.wr && i_bus.addr == ddr_pkg::OFS_SECOND_CTRL) |=> s.differential_enable == $past(i_bus.wdata[0]))
    else $error("differential enable not taken from write");

  chk_inten_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_bus.wr && i_bus.addr == ddr_pkg::OFS_INTEN_CLR && i_bus.wdata[3]) |=> !s.inten[3])
    else $error("empty enable not cleared");

  chk_urun_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_bus.wr && i_bus.addr == ddr_pkg::OFS_INTEN_CLR && !i_bus.wdata[0]) |=> s.inten[0] == $past(s.inten[0]))
    else $error("writing zero changed underrun enable");

  chk_eoc_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (wr_data[1] && !s.differential_enable && !done[1]) |=> !s.eoc[1])
    else $error("done bit survived a data write");

  chk_eoc_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    done[0] |=> s.eoc[0] && s.out[0] == $past(s.cv[0]))
    else $error("done bit or output missing after conversion");

  chk_ready_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s.st[0] == ddr_pkg::CH_OFF && cfg[0][0]) |=> !ready[0] [*2])
    else $error("ready before startup time");

  chk_irq_cause: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s.inten == 4'h0) |-> !o_int_req)
    else $error("interrupt request with all enables off");

  chk_refresh_held: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (go_rf[0] && !s.differential_enable)
    |=> s.st[0] == ddr_pkg::CH_CONV && s.cv[0] == $past(s.data[0]) && s.intflag[ddr_pkg::UNDERRUN_LSB])
    else $error("refresh did not reconvert the held value");

  chk_standby_stop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_standby && !cfg[0][ddr_pkg::CTL_RSTBY]) |=> !s.rdue[0])
    else $error("channel0 refresh due in standby without run_in_standby");

  chk_defer_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s.pend[0] && s.st[0] == ddr_pkg::CH_IDLE && cfg[0][ddr_pkg::CTL_EN_BIT]) |=> s.st[0] == ddr_pkg::CH_CONV)
    else $error("pending data did not start when the channel was free");

  chk_differential_enable_config: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s.differential_enable && s.ctrl[0][ddr_pkg::CTL_EN_BIT]) |=> s.st[1] != ddr_pkg::CH_OFF)
    else $error("channel1 not configured by channel0 control in differential mode");

  chk_ready_after: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s.st[0] == ddr_pkg::CH_START && s.tcnt[0] == TCNT_W'(STARTUP_CYC - 1) && cfg[0][ddr_pkg::CTL_EN_BIT])
    |=> ready[0])
    else $error("ready missing after startup time");

  chk_irq_raise: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s.intflag[ddr_pkg::EMPTY_LSB] && s.inten[ddr_pkg::EMPTY_LSB]) |-> o_int_req)
    else $error("interrupt request missing for an enabled flag");

  chk_eoc_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (wr_data[0] && !done[0]) |=> !s.eoc[0])
    else $error("channel0 done bit survived a data write");

  chk_empty_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    go_new[0] |=> s.intflag[ddr_pkg::EMPTY_LSB])
    else $error("empty flag not set when new data started");
endmodule : ddr_refresh_ctrl
`default_nettype wire

// file: tb/test_ddr_refresh_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) check(n, 16'(e), 16'(g))
module test_ddr_refresh_ctrl;
  localparam int         START_CYC = 8;
  localparam int         CONV_CYC  = 6;
  localparam logic [7:0] A_ST      = ddr_pkg::OFS_STATUS;
  localparam logic [7:0] A_FL      = ddr_pkg::OFS_INTFLAG;
  localparam logic [7:0] A_C0      = ddr_pkg::OFS_CH0_CTRL;
  localparam logic [7:0] A_D0      = ddr_pkg::OFS_CH0_DATA;
  logic                  i_clk;
  logic                  i_sys_rst;
  logic                  i_lp_clk;
  logic                  i_standby;
  ddr_pkg::ddr_bus_req_t i_bus;
  logic [15:0]           o_rdata;
  ddr_pkg::ddr_aout_t    o_aout;
  logic [1:0]            o_conv_done;
  logic                  o_int_req;
  logic [15:0]           rd_val;
  int                    miscompares;
  int                    checks_done;

  ddr_refresh_ctrl #(.STARTUP_CYC(START_CYC), .CONV_CYC(CONV_CYC)) ddr_refresh_ctrl_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_rdata(o_rdata), .i_lp_clk(i_lp_clk),
    .i_standby(i_standby), .o_aout(o_aout), .o_conv_done(o_conv_done), .o_int_req(o_int_req));

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask : check

  // a gap edge between strobes keeps each strobe assigned once per time step
  task automatic bus_wr(input logic [7:0] addr, input logic [15:0] data);
    @(posedge i_clk);
    i_bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    i_bus.wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] addr);
    @(posedge i_clk);
    i_bus <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    i_bus.rd <= 1'b0;
    #1;
    rd_val = o_rdata;
  endtask : bus_rd

  task automatic lp_ticks(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      i_lp_clk <= 1'b1;
      repeat (5) @(posedge i_clk);
      i_lp_clk <= 1'b0;
      repeat (5) @(posedge i_clk);
    end
    repeat (CONV_CYC + 8) @(posedge i_clk);
  endtask : lp_ticks

  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic t_startup;
    bus_rd(A_ST);
    `CHK("status after reset", 16'h0000, rd_val);
    bus_rd(8'hff);
    `CHK("unmapped read", 16'h0000, rd_val);
    bus_wr(A_C0, 16'h0001);
    bus_rd(A_ST);
    `CHK("ready before startup", 16'h0000, rd_val);
    repeat (START_CYC + 4) @(posedge i_clk);
    bus_rd(A_ST);
    `CHK("ready after startup", 16'h0001, rd_val);
    $display("test startup done");
  endtask : t_startup

  task automatic t_conv;
    bus_wr(A_D0, 16'h0123);
    repeat (CONV_CYC + 4) @(posedge i_clk);
    `CHK("out0 value", 12'h123, o_aout.positive_analog_out);
    bus_rd(A_ST);
    `CHK("ch0_conversion_done set", 16'h0005, rd_val);
    bus_wr(A_D0, 16'h0456);
    bus_rd(A_ST);
    `CHK("ch0_conversion_done cleared by write", 16'h0001, rd_val);
    repeat (CONV_CYC + 4) @(posedge i_clk);
    `CHK("conv done port", 2'b01, o_conv_done);
    $display("test conversion done");
  endtask : t_conv

  task automatic t_int;
    bus_wr(ddr_pkg::OFS_INTEN_SET, 16'h000f);
    bus_rd(ddr_pkg::OFS_INTEN_CLR);
    `CHK("enables set", 16'h000f, rd_val);
    `CHK("irq buf0_empty_int_en", 1'b1, o_int_req);
    bus_wr(ddr_pkg::OFS_INTEN_CLR, 16'h0004);
    bus_rd(ddr_pkg::OFS_INTEN_CLR);
    `CHK("clear buf0_empty_int_en", 16'h000b, rd_val);
    `CHK("irq masked", 1'b0, o_int_req);
    bus_wr(ddr_pkg::OFS_INTEN_CLR, 16'h0000);
    bus_rd(ddr_pkg::OFS_INTEN_CLR);
    `CHK("zero write no effect", 16'h000b, rd_val);
    bus_wr(ddr_pkg::OFS_INTEN_CLR, 16'h000b);
    bus_rd(ddr_pkg::OFS_INTEN_CLR);
    `CHK("clear rest", 16'h0000, rd_val);
    $display("test interrupt enables done");
  endtask : t_int

  task automatic t_refresh;
    bus_wr(A_C0, 16'h0201);
    bus_wr(A_FL, 16'h000f);
    lp_ticks(1);
    bus_rd(A_FL);
    `CHK("no refresh at one tick", 16'h0000, rd_val);
    lp_ticks(1);
    bus_rd(A_FL);
    `CHK("refresh at two ticks", 16'h0001, rd_val);
    `CHK("held value reconverted", 12'h456, o_aout.positive_analog_out);
    bus_wr(A_C0, 16'h0001);
    bus_wr(A_FL, 16'h000f);
    lp_ticks(3);
    bus_rd(A_FL);
    `CHK("refresh off", 16'h0000, rd_val);
    $display("test refresh done");
  endtask : t_refresh

  task automatic t_standby;
    @(posedge i_clk);
    i_standby <= 1'b1;
    bus_wr(A_C0, 16'h0201);
    bus_wr(A_FL, 16'h000f);
    lp_ticks(3);
    bus_rd(A_FL);
    `CHK("standby stops refresh", 16'h0000, rd_val);
    bus_wr(A_C0, 16'h0241);
    lp_ticks(2);
    bus_rd(A_FL);
    `CHK("standby keeps refresh", 16'h0001, rd_val);
    @(posedge i_clk);
    i_standby <= 1'b0;
    $display("test standby done");
  endtask : t_standby

  task automatic t_defer;
    lp_ticks(1);
    @(posedge i_clk);
    i_lp_clk <= 1'b1;
    repeat (4) @(posedge i_clk);
    bus_wr(A_D0, 16'h02aa);
    i_lp_clk <= 1'b0;
    repeat (CONV_CYC) @(posedge i_clk);
    `CHK("refresh finishes first", 12'h456, o_aout.positive_analog_out);
    repeat (CONV_CYC + 8) @(posedge i_clk);
    `CHK("deferred value out", 12'h2aa, o_aout.positive_analog_out);
    bus_rd(A_ST);
    `CHK("deferred eoc", 16'h0005, rd_val);
    bus_rd(A_D0);
    `CHK("channel0_data_value readback", 16'h02aa, rd_val);
    $display("test deferral done");
  endtask : t_defer

  task automatic t_differential_enable;
    bus_wr(A_C0, 16'h0001);
    bus_wr(ddr_pkg::OFS_SECOND_CTRL, 16'h0001);
    bus_rd(ddr_pkg::OFS_SECOND_CTRL);
    `CHK("differential_enable readback", 16'h0001, rd_val);
    bus_wr(A_D0, 16'h0801);
    repeat (CONV_CYC + 4) @(posedge i_clk);
    `CHK("differential_enable positive", 12'h001, o_aout.positive_analog_out);
    `CHK("differential_enable negative", 12'hffe, o_aout.negative_analog_out);
    `CHK("both done", 2'b11, o_conv_done);
    bus_wr(ddr_pkg::OFS_SECOND_CTRL, 16'h0000);
    bus_wr(A_D0, 16'h0055);
    repeat (CONV_CYC + 4) @(posedge i_clk);
    `CHK("single positive", 12'h055, o_aout.positive_analog_out);
    `CHK("negative untouched", 12'hffe, o_aout.negative_analog_out);
    bus_wr(ddr_pkg::OFS_CH1_DATA, 16'h0077);
    bus_rd(A_ST);
    `CHK("ch1_conversion_done cleared by write", 16'h0005, rd_val);
    bus_rd(ddr_pkg::OFS_CH1_DATA);
    `CHK("data1 readback", 16'h0077, rd_val);
    $display("test differential done");
  endtask : t_differential_enable

  initial
  begin
    i_sys_rst = 1'b1;
    i_lp_clk = 1'b0;
    i_standby = 1'b0;
    i_bus = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_startup();
    t_conv();
    t_int();
    t_refresh();
    t_standby();
    t_defer();
    t_differential_enable();
    stop_test();
  end

  // whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    stop_test();
  end
endmodule : test_ddr_refresh_ctrl
`default_nettype wire
